// [hw/protocol_timer_mode_control.sv]
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module protocol_timer_mode_control #(
  parameter int CNT_W = 16,
  parameter int DIV_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_mode_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_pulse,
  input wire timer_mode_pkg::proto_evt_t proto_evt,
  input wire timer_mode_pkg::proto_cfg_t proto_cfg,
  input wire timer_mode_pkg::gate_in_t gate_in,
  output logic timer_active_flag,
  output logic irq
);

  // all registers are at most one byte wide; only the low byte lane of pwdata is used
  // and the upper lanes are ignored rather than refused, so a word write with
  // the low strobe clear leaves the register untouched
  // register state
  logic [7:0] timer_mode_control_ff; // mode register
  logic [7:0] divider_low_byte_ff; // divider low byte
  logic [CNT_W-1:0] reload_value_ff; // reload value
  logic [timer_mode_pkg::IRQ_W-1:0] irq_status_ff; // sticky events
  logic [timer_mode_pkg::IRQ_W-1:0] irq_enable_ff; // interrupt mask
  logic timer_active_ff; // timer running
  logic [31:0] prdata_ff; // read data captured in setup

  // decoded mode fields
  // the mode byte is split into its fields once here so that every consumer
  // reads the same decode and a field move touches one place only
  logic auto_start_enable;
  timer_mode_pkg::gate_sel_t gate_select;
  logic reload_on_zero;
  logic [3:0] divider_upper_nibble;
  logic [DIV_W-1:0] divider_value;

  // bus decode
  // the bus never stalls: pready is tied high, so an access phase always
  // completes at the edge after its setup cycle; the trade is that read data
  // must be ready one cycle early, hence the capture in the setup cycle
  logic [15:0] reg_idx; // word index of the access
  logic wr_en; // write completes this edge
  logic setup; // setup phase of any access
  logic mapped; // index hits a register
  logic lane0; // low byte lane written
  logic [31:0] nxt_prdata;

  // timer control
  // start and stop sources are merged into one pair of pulses before they
  // reach the counter, so their priority is settled in one place
  logic start_now; // software start pulse
  logic stop_now_control; // software stop pulse
  logic proto_start; // start from the radio sequencer
  logic proto_stop; // stop from the radio sequencer
  logic start_evt; // merged start, after stop priority
  logic stop_evt; // merged stop
  logic gate_open; // selected gate lets steps through
  logic tick; // prescaled tick from the divider
  logic step; // counter decrements this cycle
  logic expired; // one-shot countdown ended this cycle
  logic [CNT_W-1:0] current_count; // live count value
  logic [timer_mode_pkg::IRQ_W-1:0] irq_set; // status set events
  logic [timer_mode_pkg::IRQ_W-1:0] irq_clr; // status clear mask

  // mode register fields
  assign auto_start_enable = timer_mode_control_ff[timer_mode_pkg::MODE_AUTO_BIT];
  assign gate_select = timer_mode_pkg::gate_sel_t'(
    timer_mode_control_ff[timer_mode_pkg::MODE_GATE_HI:timer_mode_pkg::MODE_GATE_LO]);
  assign reload_on_zero = timer_mode_control_ff[timer_mode_pkg::MODE_RELOAD_BIT];
  assign divider_upper_nibble =
    timer_mode_control_ff[timer_mode_pkg::MODE_DIV_HI:timer_mode_pkg::MODE_DIV_LO];
  assign divider_value = {divider_upper_nibble, divider_low_byte_ff};

  // apb decode; every access completes without wait states
  assign reg_idx = paddr[timer_mode_pkg::ADDR_W-1:timer_mode_pkg::WORD_LSB];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & mapped;
  assign lane0 = pstrb[0];
  assign pready = 1'b1;

  // index hit table
  // holes inside the window decode as unmapped and raise pslverr, which
  // catches software that writes a neighbour's address by mistake; the two
  // low address bits are ignored, as every register is one aligned word
  always_comb begin
    unique case (reg_idx)
      timer_mode_pkg::IDX_MODE,
      timer_mode_pkg::IDX_PRESC_LO,
      timer_mode_pkg::IDX_RELOAD_HI,
      timer_mode_pkg::IDX_RELOAD_LO,
      timer_mode_pkg::IDX_COUNT_HI,
      timer_mode_pkg::IDX_COUNT_LO,
      timer_mode_pkg::IDX_CONTROL,
      timer_mode_pkg::IDX_IRQ_STATUS,
      timer_mode_pkg::IDX_IRQ_CLEAR,
      timer_mode_pkg::IDX_IRQ_ENABLE,
      timer_mode_pkg::IDX_TIMER_STATUS: mapped = 1'b1;
      default: mapped = 1'b0; // unmapped index
    endcase
  end

  // unmapped addresses answer with an error in the access phase
  assign pslverr = psel & penable & ~mapped;

  // read mux; write-only registers read zero
  // the count bytes are read live, so software reading high then low may
  // see a borrow between the two reads; read twice if that matters
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (reg_idx)
      timer_mode_pkg::IDX_MODE: nxt_prdata[7:0] = timer_mode_control_ff;
      timer_mode_pkg::IDX_PRESC_LO: nxt_prdata[7:0] = divider_low_byte_ff;
      timer_mode_pkg::IDX_RELOAD_HI: nxt_prdata[7:0] = reload_value_ff[15:8];
      timer_mode_pkg::IDX_RELOAD_LO: nxt_prdata[7:0] = reload_value_ff[7:0];
      timer_mode_pkg::IDX_COUNT_HI: nxt_prdata[7:0] = current_count[15:8];
      timer_mode_pkg::IDX_COUNT_LO: nxt_prdata[7:0] = current_count[7:0];
      timer_mode_pkg::IDX_IRQ_STATUS: nxt_prdata[timer_mode_pkg::IRQ_W-1:0] = irq_status_ff;
      timer_mode_pkg::IDX_IRQ_ENABLE: nxt_prdata[timer_mode_pkg::IRQ_W-1:0] = irq_enable_ff;
      timer_mode_pkg::IDX_TIMER_STATUS: nxt_prdata[0] = timer_active_ff;
      default: nxt_prdata = 32'h0000_0000; // control, clear and holes
    endcase
  end

  // read data captured in setup so prdata comes from a flop
  // capture happens one cycle before the access phase, so a value that
  // changes in the access cycle itself is seen on the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end
  assign prdata = prdata_ff;

  // mode register
  // a mode change takes effect at once, even while the timer runs; the
  // gate, reload and divider settings are all sampled live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_control_ff <= timer_mode_pkg::MODE_RESET;
    end else if (wr_en && lane0 && reg_idx == timer_mode_pkg::IDX_MODE) begin
      timer_mode_control_ff <= pwdata[7:0];
    end
  end

  // divider low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_low_byte_ff <= timer_mode_pkg::PRESC_LO_RESET;
    end else if (wr_en && lane0 && reg_idx == timer_mode_pkg::IDX_PRESC_LO) begin
      divider_low_byte_ff <= pwdata[7:0];
    end
  end

  // reload value; the counter picks it up at a start event, and at zero in reload mode
  // the two halves are separate writes, so set both before the start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_value_ff <= timer_mode_pkg::RELOAD_RESET;
    end else if (wr_en && lane0 && reg_idx == timer_mode_pkg::IDX_RELOAD_HI) begin
      reload_value_ff[15:8] <= pwdata[7:0];
    end else if (wr_en && lane0 && reg_idx == timer_mode_pkg::IDX_RELOAD_LO) begin
      reload_value_ff[7:0] <= pwdata[7:0];
    end
  end

  // interrupt enable
  // masking hides the level output only; the status bit keeps its state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_ff <= timer_mode_pkg::IRQ_ENABLE_RESET;
    end else if (wr_en && lane0 && reg_idx == timer_mode_pkg::IDX_IRQ_ENABLE) begin
      irq_enable_ff <= pwdata[timer_mode_pkg::IRQ_W-1:0];
    end
  end

  // software start and stop pulses from the control register
  // the control register stores nothing: each written one acts for a single
  // cycle and reads back as zero
  assign start_now = wr_en & lane0 & (reg_idx == timer_mode_pkg::IDX_CONTROL)
    & pwdata[timer_mode_pkg::CTRL_START_BIT];
  assign stop_now_control = wr_en & lane0 & (reg_idx == timer_mode_pkg::IDX_CONTROL)
    & pwdata[timer_mode_pkg::CTRL_STOP_BIT];

  // protocol events only count with auto-start set
  // the sequencer pulses are one cycle wide and taken as synchronous to
  // pclk; a wider pulse would restart the timer on every cycle it stands
  assign proto_start = auto_start_enable & (proto_evt.tx_end
    | (proto_cfg.initial_field_on & proto_evt.field_on));
  // multi-frame receive leaves stopping the timer to software
  assign proto_stop = auto_start_enable & ~proto_cfg.multi_frame_receive
    & proto_evt.rx_first_bit;

  // stop wins over a start in the same cycle, so a stop is never lost
  // a start while running reloads the count and restarts the divider phase
  assign stop_evt = proto_stop | stop_now_control;
  assign start_evt = (proto_start | start_now) & ~stop_evt;

  // running flag follows the register-driven state, not the gate input
  // in gated mode the flag stays high while the gate holds the count, so
  // software sees the timer as armed rather than paused; expiry in one-shot
  // mode is the only clear that does not come from a stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_active_ff <= 1'b0;
    end else if (stop_evt) begin
      timer_active_ff <= 1'b0;
    end else if (start_evt) begin
      timer_active_ff <= 1'b1;
    end else if (expired) begin
      timer_active_ff <= 1'b0;
    end
  end
  assign timer_active_flag = timer_active_ff;

  // gate source; reserved code is treated as no gating
  // the gate inputs are levels taken as synchronous, with no filtering
  always_comb begin
    unique case (gate_select)
      timer_mode_pkg::GATE_NONE: gate_open = 1'b1;
      timer_mode_pkg::GATE_SECURE: gate_open = gate_in.secure_signal_input;
      timer_mode_pkg::GATE_AUX: gate_open = gate_in.first_auxiliary_line;
      timer_mode_pkg::GATE_RESERVED: gate_open = 1'b1;
    endcase
  end

  // count only on a tick while running and the gate is open
  // a tick that falls while the gate is closed is dropped, not deferred, so
  // a gated countdown loses exactly the ticks that the gate masks
  assign step = tick & timer_active_ff & gate_open;

  // prescaler
  // the divider restarts on every start so the first step is a full period
  tick_divider #(
    .DIV_W(DIV_W)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ref_pulse(ref_pulse),
    .restart(start_evt),
    .divisor(divider_value),
    .tick(tick)
  );

  // countdown
  // load takes priority over a step landing in the same cycle
  down_counter #(
    .CNT_W(CNT_W)
  ) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .load(start_evt),
    .step(step),
    .reload_on_zero(reload_on_zero),
    .reload_value(reload_value_ff),
    .current_count(current_count),
    .expired(expired)
  );

  // sticky status; a set in the clearing cycle wins
  // write one to clear; an expiry that lands in the clearing write's cycle
  // survives so software never loses an event
  assign irq_set = {timer_mode_pkg::IRQ_W{1'b0}} | (expired << timer_mode_pkg::IRQ_EXPIRY_BIT);
  assign irq_clr = (wr_en && lane0 && reg_idx == timer_mode_pkg::IDX_IRQ_CLEAR)
    ? pwdata[timer_mode_pkg::IRQ_W-1:0] : {timer_mode_pkg::IRQ_W{1'b0}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_ff <= '0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
    end
  end

  // level interrupt
  // combinational, so it follows a mask write in the same cycle
  assign irq = |(irq_status_ff & irq_enable_ff);

endmodule // protocol_timer_mode_control
`default_nettype wire

// [hw/timer_mode_pkg.sv]
package timer_mode_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_MODE = 16'h631A;
  localparam logic [15:0] IDX_PRESC_LO = 16'h631B;
  localparam logic [15:0] IDX_RELOAD_HI = 16'h631C;
  localparam logic [15:0] IDX_RELOAD_LO = 16'h631D;
  localparam logic [15:0] IDX_COUNT_HI = 16'h631E;
  localparam logic [15:0] IDX_COUNT_LO = 16'h631F;
  localparam logic [15:0] IDX_CONTROL = 16'h6330;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h6331;
  localparam logic [15:0] IDX_IRQ_CLEAR = 16'h6332;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'h6333;
  localparam logic [15:0] IDX_TIMER_STATUS = 16'h6334;

  // apb address width and word alignment
  localparam int ADDR_W = 18;
  localparam int WORD_LSB = 2;

  // mode register fields
  localparam int MODE_AUTO_BIT = 7;
  localparam int MODE_GATE_HI = 6;
  localparam int MODE_GATE_LO = 5;
  localparam int MODE_RELOAD_BIT = 4;
  localparam int MODE_DIV_HI = 3;
  localparam int MODE_DIV_LO = 0;

  // control register fields (write-only pulses)
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;

  // interrupt layout
  localparam int IRQ_EXPIRY_BIT = 0;
  localparam int IRQ_W = 1;

  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] PRESC_LO_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 1'h0;

  // reference rate feeding the divider, in kHz
  localparam int REF_FREQ_KHZ = 6780;

  // gating source encodings
  typedef enum logic [1:0] {
    GATE_NONE = 2'h0,
    GATE_SECURE = 2'h1,
    GATE_AUX = 2'h2,
    GATE_RESERVED = 2'h3
  } gate_sel_t;

  // protocol events from the radio sequencer, one-cycle pulses
  typedef struct packed {
    logic tx_end;
    logic field_on;
    logic rx_first_bit;
  } proto_evt_t;

  // protocol-side settings held in other registers
  typedef struct packed {
    logic initial_field_on;
    logic multi_frame_receive;
  } proto_cfg_t;

  // external gate inputs
  typedef struct packed {
    logic secure_signal_input;
    logic first_auxiliary_line;
  } gate_in_t;

endpackage

// [hw/tick_divider.sv]
`timescale 1ns/1ps
`default_nettype none
// divides the reference strobe by the 12-bit divider value
module tick_divider #(
  parameter int DIV_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ref_pulse,
  input wire logic restart,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);

  logic [DIV_W-1:0] phase_ff; // reference strobes seen since last tick
  logic tick_ff; // registered tick pulse
  logic last_phase; // this strobe closes the period

  // a divisor of zero behaves as one, so the timer never freezes silently
  assign last_phase = (phase_ff + DIV_W'(1)) >= divisor;

  // phase counter, restarted with the timer so the first tick is a full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= '0;
    end else if (restart) begin
      phase_ff <= '0;
    end else if (ref_pulse) begin
      phase_ff <= last_phase ? '0 : phase_ff + DIV_W'(1);
    end
  end

  // tick pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= ref_pulse & last_phase & ~restart;
    end
  end

  assign tick = tick_ff;

endmodule // tick_divider
`default_nettype wire

// [hw/down_counter.sv]
`timescale 1ns/1ps
`default_nettype none
// 16-bit down counter with start load and reload or stop at zero
module down_counter #(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic step,
  input wire logic reload_on_zero,
  input wire logic [CNT_W-1:0] reload_value,
  output logic [CNT_W-1:0] current_count,
  output logic expired
);

  logic [CNT_W-1:0] count_ff; // current count
  logic hits_zero; // this step ends the countdown

  // one or zero left: the step lands on zero
  assign hits_zero = (count_ff <= CNT_W'(1));

  // count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= '0;
    end else if (load) begin
      count_ff <= reload_value;
    end else if (step) begin
      if (hits_zero && reload_on_zero) begin
        count_ff <= reload_value;
      end else if (hits_zero) begin
        count_ff <= '0;
      end else begin
        count_ff <= count_ff - CNT_W'(1);
      end
    end
  end

  // expiry only when the count stops at zero
  assign expired = step & ~load & hits_zero & ~reload_on_zero;
  assign current_count = count_ff;

endmodule // down_counter
`default_nettype wire

// [testbench/timer_mode_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the timer mode block
module timer_mode_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_mode_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire timer_mode_pkg::proto_evt_t proto_evt,
  input wire timer_mode_pkg::proto_cfg_t proto_cfg,
  input wire timer_mode_pkg::gate_in_t gate_in,
  input wire logic timer_active_flag,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] mode_ff; // shadow of the mode register
  logic en_ff; // shadow of the expiry enable bit
  logic wr, stop_ev, shut;
  assign wr = psel && penable && pwrite && pstrb[0];
  // any stop source, software or protocol
  assign stop_ev = (wr && paddr == {timer_mode_pkg::IDX_CONTROL, 2'h0} && pwdata[1]) ||
    (mode_ff[7] && proto_evt.rx_first_bit && !proto_cfg.multi_frame_receive);
  // gate selected and closed, so no step can land
  assign shut = (mode_ff[6:5] == 2'h1 && !gate_in.secure_signal_input) ||
    (mode_ff[6:5] == 2'h2 && !gate_in.first_auxiliary_line);
  // shadows follow completed writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= 8'h00;
      en_ff <= 1'h0;
    end else if (wr && paddr == {timer_mode_pkg::IDX_MODE, 2'h0}) begin
      mode_ff <= pwdata[7:0];
    end else if (wr && paddr == {timer_mode_pkg::IDX_IRQ_ENABLE, 2'h0}) begin
      en_ff <= pwdata[0];
    end
  end
  sequence mode_rd_s;
    psel && !penable && !pwrite && paddr == {timer_mode_pkg::IDX_MODE, 2'h0};
  endsequence
  sequence tx_start_s;
    mode_ff[7] && proto_evt.tx_end && !stop_ev;
  endsequence
  ready_always_a: assert property (pready) else $error("pready low");
  err_in_access_a: assert property (pslverr |-> psel && penable) else $error("stray slave error");
  mode_readback_a: assert property (mode_rd_s |=> prdata == {24'h000000, $past(mode_ff)})
    else $error("mode readback wrong");
  tx_start_a: assert property (tx_start_s |=> timer_active_flag) else $error("no start on tx end");
  field_start_a: assert property (mode_ff[7] && proto_cfg.initial_field_on && proto_evt.field_on && !stop_ev
    |=> timer_active_flag) else $error("no start on field");
  rx_stop_a: assert property (mode_ff[7] && proto_evt.rx_first_bit && !proto_cfg.multi_frame_receive
    |=> !timer_active_flag) else $error("no stop on first bit");
  auto_off_a: assert property (!mode_ff[7] && !timer_active_flag && !wr && (|proto_evt)
    |=> !timer_active_flag) else $error("protocol started timer");
  gated_hold_a: assert property (timer_active_flag && shut && !stop_ev |=> timer_active_flag)
    else $error("timer halted while gate closed");
  expiry_mode_a: assert property ($fell(timer_active_flag) && !$past(stop_ev) |-> !$past(mode_ff[4]))
    else $error("halt in reload mode");
  irq_mask_a: assert property (irq |-> en_ff) else $error("irq while disabled");
endmodule // timer_mode_properties
bind protocol_timer_mode_control timer_mode_properties u_timer_mode_properties (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .proto_evt(proto_evt), .proto_cfg(proto_cfg), .gate_in(gate_in),
  .timer_active_flag(timer_active_flag), .irq(irq));
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// register-level test of the protocol timer block
module tb;
  logic pclk, presetn, psel, penable, pwrite, ref_pulse, pready, pslverr, timer_active_flag, irq, rerr;
  logic [timer_mode_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  timer_mode_pkg::proto_evt_t proto_evt;
  timer_mode_pkg::proto_cfg_t proto_cfg;
  timer_mode_pkg::gate_in_t gate_in;
  int n_mismatch, checked;
  // readable registers that reset to zero
  logic [15:0] zidx [7] = '{timer_mode_pkg::IDX_MODE, timer_mode_pkg::IDX_PRESC_LO, timer_mode_pkg::IDX_RELOAD_HI,
    timer_mode_pkg::IDX_RELOAD_LO, timer_mode_pkg::IDX_IRQ_STATUS, timer_mode_pkg::IDX_IRQ_ENABLE,
    timer_mode_pkg::IDX_TIMER_STATUS};
  protocol_timer_mode_control u_protocol_timer_mode_control (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_pulse(ref_pulse), .proto_evt(proto_evt), .proto_cfg(proto_cfg),
    .gate_in(gate_in), .timer_active_flag(timer_active_flag), .irq(irq));
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  task tally_and_finish;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // settles one step, then compares
  task chk(input logic [31:0] got, input logic [31:0] exp);
    #1;
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready under a bound
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      n_mismatch++;
      tally_and_finish;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // let the completing edge settle before any caller samples an output
    #1;
  endtask
  task rc(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'h0, idx, 32'h0);
    chk(rdat, exp);
  endtask
  // n reference strobes, two cycles apart
  task pul(input int n);
    repeat (n) begin
      @(posedge pclk) ref_pulse <= 1'h1;
      @(posedge pclk) ref_pulse <= 1'h0;
    end
    repeat (3) @(posedge pclk);
  endtask
  // one protocol pulse, then the running flag
  task ev(input timer_mode_pkg::proto_evt_t e, input logic exp);
    @(posedge pclk) proto_evt <= e;
    @(posedge pclk) proto_evt <= 3'h0;
    repeat (2) @(posedge pclk);
    chk(32'(timer_active_flag), 32'(exp));
  endtask
  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = '0; pwdata = 32'h0;
    pstrb = 4'hF; ref_pulse = 1'h0; proto_evt = 3'h0; proto_cfg = 2'h0; gate_in = 2'h0;
    n_mismatch = 0;
    checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 7; i++) rc(zidx[i], 32'h0);
    apb(1'h1, timer_mode_pkg::IDX_MODE, 32'h5A);
    rc(timer_mode_pkg::IDX_MODE, 32'h5A);
    // low strobe clear: write ignored
    pstrb <= 4'hE;
    apb(1'h1, timer_mode_pkg::IDX_MODE, 32'hFF);
    pstrb <= 4'hF;
    rc(timer_mode_pkg::IDX_MODE, 32'h5A);
    apb(1'h1, 16'h6340, 32'h1);
    chk(32'(rerr), 32'h1);
    apb(1'h0, 16'h6340, 32'h0);
    chk(32'(rerr), 32'h1);
    // one-shot count, divider 256 from the upper nibble alone
    apb(1'h1, timer_mode_pkg::IDX_MODE, 32'h01);
    apb(1'h1, timer_mode_pkg::IDX_RELOAD_LO, 32'h03);
    apb(1'h1, timer_mode_pkg::IDX_IRQ_ENABLE, 32'h1);
    apb(1'h1, timer_mode_pkg::IDX_CONTROL, 32'h1);
    rc(timer_mode_pkg::IDX_COUNT_LO, 32'h3);
    pul(255);
    rc(timer_mode_pkg::IDX_COUNT_LO, 32'h3);
    pul(1);
    rc(timer_mode_pkg::IDX_COUNT_LO, 32'h2);
    pul(512);
    rc(timer_mode_pkg::IDX_COUNT_LO, 32'h0);
    chk(32'(timer_active_flag), 32'h0);
    chk(32'(irq), 32'h1);
    apb(1'h1, timer_mode_pkg::IDX_IRQ_ENABLE, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'h1, timer_mode_pkg::IDX_IRQ_ENABLE, 32'h1);
    rc(timer_mode_pkg::IDX_IRQ_STATUS, 32'h1);
    apb(1'h1, timer_mode_pkg::IDX_IRQ_CLEAR, 32'h1);
    chk(32'(irq), 32'h0);
    // reload mode, divider 1 from the low byte
    apb(1'h1, timer_mode_pkg::IDX_MODE, 32'h10);
    apb(1'h1, timer_mode_pkg::IDX_PRESC_LO, 32'h01);
    apb(1'h1, timer_mode_pkg::IDX_CONTROL, 32'h1);
    pul(3);
    rc(timer_mode_pkg::IDX_COUNT_LO, 32'h3);
    rc(timer_mode_pkg::IDX_IRQ_STATUS, 32'h0);
    apb(1'h1, timer_mode_pkg::IDX_RELOAD_LO, 32'h05);
    pul(1);
    rc(timer_mode_pkg::IDX_COUNT_LO, 32'h2);
    apb(1'h1, timer_mode_pkg::IDX_CONTROL, 32'h2);
    chk(32'(timer_active_flag), 32'h0);
    // every gate code with both inputs low, then secure input high
    for (int g = 0; g < 5; g++) begin
      gate_in <= (g == 4) ? 2'h2 : 2'h0;
      apb(1'h1, timer_mode_pkg::IDX_MODE, (g == 4) ? 32'h20 : 32'(g << 5));
      apb(1'h1, timer_mode_pkg::IDX_CONTROL, 32'h1);
      pul(1);
      rc(timer_mode_pkg::IDX_COUNT_LO, (g == 1 || g == 2) ? 32'h5 : 32'h4);
      chk(32'(timer_active_flag), 32'h1);
      rc(timer_mode_pkg::IDX_TIMER_STATUS, 32'h1);
    end
    // protocol start and stop sources
    apb(1'h1, timer_mode_pkg::IDX_CONTROL, 32'h2);
    apb(1'h1, timer_mode_pkg::IDX_MODE, 32'h80);
    ev(3'h4, 1'h1);
    ev(3'h1, 1'h0);
    ev(3'h2, 1'h0);
    proto_cfg <= 2'h2;
    ev(3'h2, 1'h1);
    proto_cfg <= 2'h1;
    ev(3'h1, 1'h1);
    apb(1'h1, timer_mode_pkg::IDX_CONTROL, 32'h2);
    chk(32'(timer_active_flag), 32'h0);
    apb(1'h1, timer_mode_pkg::IDX_MODE, 32'h00);
    ev(3'h4, 1'h0);
    apb(1'h1, timer_mode_pkg::IDX_CONTROL, 32'h1);
    proto_cfg <= 2'h0;
    ev(3'h1, 1'h1);
    // high byte path of reload and count; reload waits for the next start
    apb(1'h1, timer_mode_pkg::IDX_RELOAD_HI, 32'h12);
    rc(timer_mode_pkg::IDX_RELOAD_HI, 32'h12);
    rc(timer_mode_pkg::IDX_COUNT_HI, 32'h0);
    apb(1'h1, timer_mode_pkg::IDX_CONTROL, 32'h1);
    rc(timer_mode_pkg::IDX_COUNT_HI, 32'h12);
    rc(timer_mode_pkg::IDX_COUNT_LO, 32'h5);
    tally_and_finish;
  end
  // hang guard, about 80000 cycles
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
